// File: tpo_top.sv
// Purpose: Timing pattern output unit with AXI4-Lite registers.
// Assumes: Compare-match inputs are one-cycle pulses on aclk.
// Notes:   Pattern words from the DMA stream refill next data.
// Contract
// - Outputs form four groups of four bits, each running independently.
// - Sixteen pattern bits, each enabled separately.
// - Each group picks its trigger from four timer compare-match signals.
// - Non-overlap mode delays rising bits by a margin after falling ones.
// - A selected trigger also requests a DMA transfer of the next pattern when its group has an enabled bit.
// - Bits 0-3 group 0, 4-7 group 1, 8-11 group 2, 12-15 group 3.
// - Port direction registers are eight bits and write-only.
// - First port data holds groups 0 and 1 output data.
// - First port data bits enabled for pattern output ignore writes.
// - Second port data bits enabled for pattern output ignore writes.
// - Groups 0/1 next data at ffa5, or split ffa5/ffa7 if triggers differ.
// - Groups 2/3 next data at ffa4, or split ffa4/ffa6 if triggers differ.
// - Reset gives mode f0, control ff, all other registers 00.
// - On a group trigger its next data goes into the port data bits.
// - Shared layout puts higher group in upper nibble.
// - Reserved next-data bits ignore writes and read as ones.
`timescale 1ns/1ps
module tpo_top (
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic                 awvalid,
	output logic                      awready,
	input  wire logic [31:0]          awaddr,
	input  wire logic [2:0]           awprot,
	input  wire logic                 wvalid,
	output logic                      wready,
	input  wire logic [31:0]          wdata,
	input  wire logic [3:0]           wstrb,
	output logic                      bvalid,
	input  wire logic                 bready,
	output logic [1:0]                bresp,
	input  wire logic                 arvalid,
	output logic                      arready,
	input  wire logic [31:0]          araddr,
	input  wire logic [2:0]           arprot,
	output logic                      rvalid,
	input  wire logic                 rready,
	output logic [31:0]               rdata,
	output logic [1:0]                rresp,
	input  wire logic [3:0]           cm_match,
	input  wire logic                 pat_valid,
	input  wire logic [15:0]          pat_data,
	output logic                      pat_ready,
	output logic [3:0]                dma_req,
	output tpo_pkg::tpo_pins_type     pins
);
	import tpo_pkg::*;

	typedef struct packed {
		tpo_regs_type   rg;
		logic [3:0][3:0] cnt;
		logic [3:0][3:0] pend;
		logic [3:0]     dma_req;
		logic           reload;
		logic           aw_have;
		logic           w_have;
		logic [31:0]    aw_addr;
		logic [7:0]     w_data;
		logic           w_lane0;
		logic           awready;
		logic           wready;
		logic           bvalid;
		logic [1:0]     bresp;
		logic           arready;
		logic           rvalid;
		logic [31:0]    rdata;
		logic [1:0]     rresp;
		tpo_pins_type   pins;
	} tpo_state_type;

	tpo_state_type s_r;
	tpo_state_type s_nxt;
	logic          fifo_vld;
	logic [15:0]   fifo_dat;
	logic          fifo_pop;
	logic [3:0]    trig;
	logic          same01;
	logic          same23;

	// Read view of one index; bit 8 flags an unmapped index
	function automatic logic [8:0] rd_val(input tpo_regs_type r, input logic [15:0] i);
		logic s01;
		logic s23;
		s01 = r.pattern_output_control[1:0] == r.pattern_output_control[3:2];
		s23 = r.pattern_output_control[5:4] == r.pattern_output_control[7:6];
		case (i)
			IDX_MODE:      rd_val = {1'b0, r.pattern_output_mode};
			IDX_CTRL:      rd_val = {1'b0, r.pattern_output_control};
			IDX_NDE_HI:    rd_val = {1'b0, r.next_data_enable_hi};
			IDX_NDE_LO:    rd_val = {1'b0, r.next_data_enable_lo};
			IDX_ND_HI:     rd_val = {1'b0, s23 ? r.next_data_hi : {r.next_data_hi[7:4], RSVD_BYTE[3:0]}};
			IDX_ND_HI_ALT: rd_val = {1'b0, s23 ? RSVD_BYTE : {RSVD_BYTE[7:4], r.next_data_hi[3:0]}};
			IDX_ND_LO:     rd_val = {1'b0, s01 ? r.next_data_lo : {r.next_data_lo[7:4], RSVD_BYTE[3:0]}};
			IDX_ND_LO_ALT: rd_val = {1'b0, s01 ? RSVD_BYTE : {RSVD_BYTE[7:4], r.next_data_lo[3:0]}};
			// Write-only direction registers give nothing back
			IDX_PA_DIR:    rd_val = {1'b0, WO_READ};
			IDX_PB_DIR:    rd_val = {1'b0, WO_READ};
			IDX_PA_DATA:   rd_val = {1'b0, r.first_port_output_data};
			IDX_PB_DATA:   rd_val = {1'b0, r.second_port_output_data};
			default:       rd_val = {1'b1, RST_ZERO};
		endcase
	endfunction

	tpo_fifo #(
		.W (PAT_W),
		.D (FIFO_DEP)
	) u_fifo (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.in_valid  (pat_valid),
		.in_data   (pat_data),
		.in_ready  (pat_ready),
		.out_valid (fifo_vld),
		.out_data  (fifo_dat),
		.out_ready (fifo_pop)
	);

	always_comb begin
		logic [15:0] dat;
		logic [15:0] en;
		logic [15:0] nd;
		logic [15:0] nnd;
		logic [15:0] wr_idx;
		logic [8:0]  wchk;
		logic [8:0]  rchk;
		logic        wr_err;
		logic [1:0]  sel;
		logic [3:0]  msk;
		logic [3:0]  ndg;
		logic [3:0]  cur;
		sel = '0;
		msk = '0;
		ndg = '0;
		cur = '0;
		s_nxt = s_r;
		dat = {s_r.rg.second_port_output_data, s_r.rg.first_port_output_data};
		en = {s_r.rg.next_data_enable_hi, s_r.rg.next_data_enable_lo};
		nd = {s_r.rg.next_data_hi, s_r.rg.next_data_lo};
		nnd = nd;
		same01 = s_r.rg.pattern_output_control[1:0] == s_r.rg.pattern_output_control[3:2];
		same23 = s_r.rg.pattern_output_control[5:4] == s_r.rg.pattern_output_control[7:6];
		wr_idx = s_r.aw_addr[IDX_MSB:IDX_LSB];
		wchk = rd_val(s_r.rg, wr_idx);
		wr_err = wchk[8] | (|s_r.aw_addr[31:IDX_MSB+1]);
		rchk = rd_val(s_r.rg, araddr[IDX_MSB:IDX_LSB]);
		s_nxt.dma_req = '0;
		trig = '0;

		// Address and data are taken independently, in either order
		if (awvalid && s_r.awready) begin
			s_nxt.aw_have = 1'b1;
			s_nxt.aw_addr = awaddr;
		end
		if (wvalid && s_r.wready) begin
			s_nxt.w_have = 1'b1;
			s_nxt.w_data = wdata[7:0];
			s_nxt.w_lane0 = wstrb[0];
		end
		if (s_r.aw_have && s_r.w_have && !s_r.bvalid) begin
			s_nxt.aw_have = 1'b0;
			s_nxt.w_have = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = wr_err ? RESP_DECERR : RESP_OKAY;
			if (!wr_err && s_r.w_lane0) begin
				case (wr_idx)
					// Upper mode nibble is fixed high
					IDX_MODE:      s_nxt.rg.pattern_output_mode = {RST_MODE[7:4], s_r.w_data[3:0]};
					IDX_CTRL:      s_nxt.rg.pattern_output_control = s_r.w_data;
					IDX_NDE_HI:    s_nxt.rg.next_data_enable_hi = s_r.w_data;
					IDX_NDE_LO:    s_nxt.rg.next_data_enable_lo = s_r.w_data;
					IDX_ND_HI: begin
						if (same23) begin
							nnd[15:8] = s_r.w_data;
						end else begin
							nnd[15:12] = s_r.w_data[7:4];
						end
					end
					IDX_ND_HI_ALT: begin
						if (!same23) begin
							nnd[11:8] = s_r.w_data[3:0];
						end
					end
					IDX_ND_LO: begin
						if (same01) begin
							nnd[7:0] = s_r.w_data;
						end else begin
							nnd[7:4] = s_r.w_data[7:4];
						end
					end
					IDX_ND_LO_ALT: begin
						if (!same01) begin
							nnd[3:0] = s_r.w_data[3:0];
						end
					end
					IDX_PA_DIR:    s_nxt.rg.first_port_direction = s_r.w_data;
					IDX_PB_DIR:    s_nxt.rg.second_port_direction = s_r.w_data;
					IDX_PA_DATA:   dat[7:0] = (dat[7:0] & en[7:0]) | (s_r.w_data & ~en[7:0]);
					IDX_PB_DATA:   dat[15:8] = (dat[15:8] & en[15:8]) | (s_r.w_data & ~en[15:8]);
					default: ;
				endcase
			end
		end
		if (s_r.bvalid && bready) begin
			s_nxt.bvalid = 1'b0;
		end

		if (arvalid && s_r.arready) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rdata = {24'h000000, rchk[7:0]};
			s_nxt.rresp = (rchk[8] | (|araddr[31:IDX_MSB+1])) ? RESP_DECERR : RESP_OKAY;
		end else if (s_r.rvalid && rready) begin
			s_nxt.rvalid = 1'b0;
		end

		// Pending pattern is consumed before a new trigger is served
		if (fifo_pop) begin
			s_nxt.reload = 1'b0;
			nnd = fifo_dat;
		end

		for (int g = 0; g < NGRP; g++) begin
			sel = s_r.rg.pattern_output_control[SEL_W*g +: SEL_W];
			trig[g] = cm_match[sel];
			msk = en[GRP_W*g +: GRP_W];
			ndg = nd[GRP_W*g +: GRP_W];
			cur = dat[GRP_W*g +: GRP_W];
			if (trig[g]) begin
				// A retrigger flushes any rising bits still waiting
				if (s_r.cnt[g] != '0) begin
					cur = (cur & ~msk) | (s_r.pend[g] & msk);
				end
				if (s_r.rg.pattern_output_mode[g]) begin
					cur = cur & ~(msk & ~ndg);
					s_nxt.pend[g] = ndg;
					s_nxt.cnt[g] = NOVL_CYCLES;
				end else begin
					cur = (cur & ~msk) | (ndg & msk);
					s_nxt.cnt[g] = '0;
				end
				s_nxt.dma_req[g] = |msk;
				if (|msk) begin
					s_nxt.reload = 1'b1;
				end
			end else if (s_r.cnt[g] != '0) begin
				s_nxt.cnt[g] = s_r.cnt[g] - 1'b1;
				if (s_r.cnt[g] == 4'h1) begin
					cur = (cur & ~msk) | (s_r.pend[g] & msk);
				end
			end
			dat[GRP_W*g +: GRP_W] = cur;
		end

		s_nxt.rg.first_port_output_data = dat[7:0];
		s_nxt.rg.second_port_output_data = dat[15:8];
		s_nxt.rg.next_data_hi = nnd[15:8];
		s_nxt.rg.next_data_lo = nnd[7:0];
		s_nxt.pins.level = dat;
		s_nxt.pins.oe = {s_nxt.rg.second_port_direction, s_nxt.rg.first_port_direction};
		s_nxt.awready = !s_nxt.aw_have && !s_nxt.bvalid;
		s_nxt.wready = !s_nxt.w_have && !s_nxt.bvalid;
		s_nxt.arready = !s_nxt.rvalid;
	end

	// Pop is combinational from registered state, so the FIFO sees no loop
	assign fifo_pop = s_r.reload && fifo_vld;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
			s_r.rg.pattern_output_mode <= RST_MODE;
			s_r.rg.pattern_output_control <= RST_CTRL;
			s_r.awready <= 1'b1;
			s_r.wready <= 1'b1;
			s_r.arready <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign awready = s_r.awready;
	assign wready = s_r.wready;
	assign bvalid = s_r.bvalid;
	assign bresp = s_r.bresp;
	assign arready = s_r.arready;
	assign rvalid = s_r.rvalid;
	assign rdata = s_r.rdata;
	assign rresp = s_r.rresp;
	assign dma_req = s_r.dma_req;
	assign pins = s_r.pins;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	property p_reset_vals;
		$rose(aresetn) |-> s_r.rg.pattern_output_mode == RST_MODE && s_r.rg.pattern_output_control == RST_CTRL
			&& s_r.rg.next_data_lo == RST_ZERO && s_r.rg.first_port_output_data == RST_ZERO && pins == '0;
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

	property p_copy_g0;
		trig[0] && !s_r.rg.pattern_output_mode[0]
			|=> ((pins.level[3:0] ^ $past(s_r.rg.next_data_lo[3:0])) & $past(s_r.rg.next_data_enable_lo[3:0])) == 4'h0;
	endproperty
	a_copy_g0: assert property (p_copy_g0) else $error("group 0 not updated on trigger");

	property p_ro_lo;
		!(trig[0] || trig[1]) && s_r.cnt[0] == 4'h0 && s_r.cnt[1] == 4'h0
			|=> ((s_r.rg.first_port_output_data ^ $past(s_r.rg.first_port_output_data))
			& $past(s_r.rg.next_data_enable_lo)) == 8'h00;
	endproperty
	a_ro_lo: assert property (p_ro_lo) else $error("enabled first port bit changed by write");

	property p_ro_hi;
		!(trig[2] || trig[3]) && s_r.cnt[2] == 4'h0 && s_r.cnt[3] == 4'h0
			|=> ((s_r.rg.second_port_output_data ^ $past(s_r.rg.second_port_output_data))
			& $past(s_r.rg.next_data_enable_hi)) == 8'h00;
	endproperty
	a_ro_hi: assert property (p_ro_hi) else $error("enabled second port bit changed by write");

	property p_rsvd_read;
		arvalid && arready && araddr == {14'h0000, IDX_ND_LO_ALT, 2'h0} && same01
			|=> rvalid && rdata[7:0] == RSVD_BYTE;
	endproperty
	a_rsvd_read: assert property (p_rsvd_read) else $error("reserved byte not all ones");

	property p_split_lo;
		arvalid && arready && araddr == {14'h0000, IDX_ND_LO, 2'h0} && !same01
			|=> rvalid && rdata[3:0] == RSVD_BYTE[3:0] && rdata[7:4] == $past(s_r.rg.next_data_lo[7:4]);
	endproperty
	a_split_lo: assert property (p_split_lo) else $error("split layout read wrong");

	property p_same_hi;
		arvalid && arready && araddr == {14'h0000, IDX_ND_HI, 2'h0} && same23
			|=> rdata[7:0] == $past(s_r.rg.next_data_hi);
	endproperty
	a_same_hi: assert property (p_same_hi) else $error("shared layout read wrong");

	property p_dma;
		dma_req[2] == $past(trig[2] && (|s_r.rg.next_data_enable_hi[3:0]));
	endproperty
	a_dma: assert property (p_dma) else $error("dma request does not follow trigger");

	property p_novl;
		trig[0] && s_r.rg.pattern_output_mode[0] && s_r.rg.next_data_enable_lo[0]
			&& !pins.level[0] && s_r.rg.next_data_lo[0] && s_r.cnt[0] == 4'h0
			|=> (!pins.level[0] && !trig[0]) [*4] ##1 pins.level[0];
	endproperty
	a_novl: assert property (p_novl) else $error("non-overlap margin wrong");

	property p_reload;
		fifo_pop |=> {s_r.rg.next_data_hi, s_r.rg.next_data_lo} == $past(fifo_dat);
	endproperty
	a_reload: assert property (p_reload) else $error("fifo word not loaded");
endmodule

// File: tpo_pkg.sv
// Purpose: Shared constants and carriers for the timing pattern output unit.
// Assumes: Register offsets are word indexes; byte address is four times the index.
// Notes:   Mode and control field layouts are local decisions.
package tpo_pkg;
	localparam int unsigned NGRP     = 4;
	localparam int unsigned GRP_W    = 4;
	localparam int unsigned PAT_W    = 16;
	localparam int unsigned FIFO_DEP = 16;
	localparam int unsigned SEL_W    = 2;

	localparam logic [15:0] IDX_MODE       = 16'hffa0;
	localparam logic [15:0] IDX_CTRL       = 16'hffa1;
	localparam logic [15:0] IDX_NDE_HI     = 16'hffa2;
	localparam logic [15:0] IDX_NDE_LO     = 16'hffa3;
	localparam logic [15:0] IDX_ND_HI      = 16'hffa4;
	localparam logic [15:0] IDX_ND_LO      = 16'hffa5;
	localparam logic [15:0] IDX_ND_HI_ALT  = 16'hffa6;
	localparam logic [15:0] IDX_ND_LO_ALT  = 16'hffa7;
	localparam logic [15:0] IDX_PA_DIR     = 16'hffd1;
	localparam logic [15:0] IDX_PA_DATA    = 16'hffd3;
	localparam logic [15:0] IDX_PB_DIR     = 16'hffd4;
	localparam logic [15:0] IDX_PB_DATA    = 16'hffd6;

	// Address bits above the index must be zero
	localparam int unsigned IDX_LSB = 2;
	localparam int unsigned IDX_MSB = 17;

	localparam logic [7:0] RST_MODE = 8'hf0;
	localparam logic [7:0] RST_CTRL = 8'hff;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RSVD_BYTE = 8'hff;
	localparam logic [7:0] WO_READ  = 8'h00;

	// Non-overlap margin before rising bits are applied
	localparam logic [3:0] NOVL_CYCLES = 4'h4;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef struct packed {
		logic [7:0] pattern_output_mode;
		logic [7:0] pattern_output_control;
		logic [7:0] next_data_enable_hi;
		logic [7:0] next_data_enable_lo;
		logic [7:0] next_data_hi;
		logic [7:0] next_data_lo;
		logic [7:0] first_port_direction;
		logic [7:0] first_port_output_data;
		logic [7:0] second_port_direction;
		logic [7:0] second_port_output_data;
	} tpo_regs_type;

	typedef struct packed {
		logic [PAT_W-1:0] level;
		logic [PAT_W-1:0] oe;
	} tpo_pins_type;
endpackage

// File: tpo_fifo.sv
// Purpose: Pattern word FIFO between the DMA stream and the next-data registers.
// Assumes: Single clock, synchronous active-low reset.
// Notes:   in_ready is registered, so it is one cycle conservative.
`timescale 1ns/1ps
module tpo_fifo #(
	parameter int unsigned W = 16,
	parameter int unsigned D = 16
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	output logic              in_ready,
	output logic              out_valid,
	output logic [W-1:0]      out_data,
	input  wire logic         out_ready
);
	localparam int unsigned AW = $clog2(D);
	localparam logic [AW:0] FULL = (AW+1)'(D);

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0]       wp;
		logic [AW-1:0]       rp;
		logic [AW:0]         cnt;
		logic                rdy;
	} tpo_fifo_state_type;

	tpo_fifo_state_type s_r;
	tpo_fifo_state_type s_nxt;
	logic               push;
	logic               pop;

	always_comb begin
		s_nxt = s_r;
		push = in_valid && s_r.rdy;
		pop = out_ready && (s_r.cnt != '0);
		if (push) begin
			s_nxt.mem[s_r.wp] = in_data;
			s_nxt.wp = s_r.wp + 1'b1;
		end
		if (pop) begin
			s_nxt.rp = s_r.rp + 1'b1;
		end
		if (push && !pop) begin
			s_nxt.cnt = s_r.cnt + 1'b1;
		end else if (pop && !push) begin
			s_nxt.cnt = s_r.cnt - 1'b1;
		end
		s_nxt.rdy = s_nxt.cnt != FULL;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign in_ready = s_r.rdy;
	assign out_valid = s_r.cnt != '0;
	assign out_data = s_r.mem[s_r.rp];
endmodule

// File: tpo_pin_load.sv
// Purpose: Load on the pattern pins that resolves each pad level.
// Assumes: Every pad carries a weak pull-down.
// Notes:   Undriven pads settle low, so stale levels cannot pass a check.
`timescale 1ns/1ps
module tpo_pin_load (
	input  wire tpo_pkg::tpo_pins_type pins,
	output logic [15:0]                pad
);
	import tpo_pkg::*;

	// Pull-down wins wherever the unit releases a pin
	assign pad = pins.level & pins.oe;
endmodule

// File: testbench.sv
// Purpose: Self-checking bench for the timing pattern output unit.
// Assumes: Seed 59; the unit is reached only through its ports.
// Notes:   Expected values come from bench functions, never from outputs.
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin fails++; \
	$display("[ERR] %s exp %h got %h", nm, ex, gt); end end
module testbench;
	import tpo_pkg::*;
	logic          aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
	logic          arvalid = 0, rready = 0, pat_valid = 0;
	logic [31:0]   awaddr = 0, wdata = 0, araddr = 0, rdata, rdat;
	logic [1:0]    bresp, rresp, rsp;
	logic          awready, wready, bvalid, arready, rvalid, pat_ready;
	logic [3:0]    cm_match = 0, dma_req, o, n, e;
	logic [15:0]   pat_data = 0, pad, w;
	logic [15:0]   q[$];
	logic [7:0]    d, h, l, p, pa, pb;
	tpo_pins_type  pins;
	int            fails = 0, n_tests = 0, k;
	logic [15:0]   ridx[12] = '{IDX_MODE, IDX_CTRL, IDX_NDE_HI, IDX_NDE_LO, IDX_ND_HI, IDX_ND_LO,
		IDX_ND_HI_ALT, IDX_ND_LO_ALT, IDX_PA_DIR, IDX_PA_DATA, IDX_PB_DIR, IDX_PB_DATA};
	logic [7:0]    rexp[12] = '{8'hf0, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff,
		8'h00, 8'h00, 8'h00, 8'h00};

	always #12.5 aclk = ~aclk;

	tpo_top uut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'h1), .bvalid(bvalid),
		.bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
		.arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.cm_match(cm_match), .pat_valid(pat_valid), .pat_data(pat_data), .pat_ready(pat_ready),
		.dma_req(dma_req), .pins(pins));
	tpo_pin_load load_u (.pins(pins), .pad(pad));

	function automatic logic [7:0] merge(input logic [7:0] en, old, wv);
		return (old & en) | (wv & ~en);
	endfunction

	function automatic logic [3:0] novl(input logic [3:0] old, nw, input bit rise);
		return rise ? nw : (old & nw);
	endfunction

	// Leading edge keeps two calls from driving one signal in one step
	task automatic wr(input logic [15:0] idx, input logic [7:0] dv);
		@(posedge aclk);
		awaddr  <= {14'h0, idx, 2'h0};
		wdata   <= {24'h0, dv};
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		for (k = 0; k < 200 && (awvalid || wvalid || !bvalid); k++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end
		rsp = bresp;
		bready <= 1'b0;
		// A write that never answers is a mismatch, not a silent pass
		if (k >= 200) fails++;
	endtask

	task automatic rd(input logic [15:0] idx);
		@(posedge aclk);
		araddr  <= {14'h0, idx, 2'h0};
		arvalid <= 1'b1;
		rready  <= 1'b1;
		for (k = 0; k < 200 && (arvalid || !rvalid); k++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end
		rsp  = rresp;
		rdat = rdata;
		rready <= 1'b0;
		if (k >= 200) fails++;
	endtask

	task automatic rchk(input logic [15:0] idx, input logic [7:0] ex);
		rd(idx);
		`CHK("rresp", RESP_OKAY, rsp)
		`CHK("rdata", {24'h0, ex}, rdat)
	endtask

	// Returns mid-cycle after the edge that took the pulse, away from any launch edge
	task automatic trig(input int ch);
		@(posedge aclk);
		cm_match <= 4'h1 << ch;
		@(posedge aclk);
		cm_match <= 4'h0;
		@(negedge aclk);
	endtask

	task automatic results();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		#500000;
		fails++;
		results();
	end

	initial begin
		void'($urandom(59));
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (ridx[i]) rchk(ridx[i], rexp[i]);
		rd(16'hffa8);
		`CHK("unmapped", RESP_DECERR, rsp)
		$display("test reset done");

		d = 8'($urandom);
		wr(IDX_PA_DIR, d);
		`CHK("bresp", RESP_OKAY, rsp)
		wr(IDX_PB_DIR, ~d);
		rchk(IDX_PA_DIR, WO_READ);
		`CHK("oe", {~d, d}, pins.oe)
		wr(IDX_PA_DIR, 8'hff);
		wr(IDX_PB_DIR, 8'hff);
		$display("test direction done");

		wr(IDX_CTRL, 8'h00);
		wr(IDX_NDE_HI, 8'hff);
		wr(IDX_NDE_LO, 8'hff);
		h = 8'($urandom);
		l = 8'($urandom);
		wr(IDX_ND_HI, h);
		wr(IDX_ND_LO, l);
		wr(IDX_ND_LO_ALT, 8'h00);
		rchk(IDX_ND_LO_ALT, RSVD_BYTE);
		rchk(IDX_ND_LO, l);
		trig(0);
		`CHK("pad", {h, l}, pad)
		`CHK("dma", 4'hf, dma_req)
		wr(IDX_NDE_LO, 8'h0f);
		wr(IDX_NDE_HI, 8'hf0);
		p = 8'($urandom);
		wr(IDX_PA_DATA, p);
		wr(IDX_PB_DATA, ~p);
		pa = merge(8'h0f, l, p);
		pb = merge(8'hf0, h, ~p);
		rchk(IDX_PA_DATA, pa);
		rchk(IDX_PB_DATA, pb);
		$display("test shared done");

		// Groups 0/1 and 2/3 both split
		wr(IDX_CTRL, 8'h49);
		wr(IDX_NDE_LO, 8'hff);
		wr(IDX_NDE_HI, 8'h00);
		h = 8'($urandom);
		l = 8'($urandom);
		wr(IDX_ND_LO, h);
		wr(IDX_ND_LO_ALT, l);
		wr(IDX_ND_HI, h);
		wr(IDX_ND_HI_ALT, l);
		rchk(IDX_ND_LO, {h[7:4], 4'hf});
		rchk(IDX_ND_LO_ALT, {4'hf, l[3:0]});
		rchk(IDX_ND_HI, {h[7:4], 4'hf});
		rchk(IDX_ND_HI_ALT, {4'hf, l[3:0]});
		trig(1);
		`CHK("g0", {pa[7:4], l[3:0]}, pad[7:0])
		`CHK("dma", 4'h1, dma_req)
		trig(2);
		`CHK("g1", {h[7:4], l[3:0]}, pad[7:0])
		`CHK("dma", 4'h2, dma_req)
		$display("test split done");

		// Bit 0 forced low then high, so the margin on a rising bit is exercised
		o = 4'($urandom) & 4'he;
		n = 4'($urandom) | 4'h1;
		wr(IDX_ND_LO_ALT, {4'h0, o});
		trig(1);
		wr(IDX_MODE, 8'h01);
		rchk(IDX_MODE, 8'hf1);
		wr(IDX_ND_LO_ALT, {4'h0, n});
		trig(1);
		`CHK("novl", novl(o, n, 0), pad[3:0])
		repeat (3) @(negedge aclk);
		`CHK("novl", novl(o, n, 0), pad[3:0])
		@(negedge aclk);
		`CHK("novl", novl(o, n, 1), pad[3:0])
		wr(IDX_MODE, 8'h00);
		$display("test margin done");

		// Fill until refused, then drain one word per trigger
		wr(IDX_CTRL, 8'hfc);
		wr(IDX_NDE_LO, 8'h0f);
		wr(IDX_ND_LO_ALT, 8'h0a);
		w = 16'($urandom);
		k = 0;
		@(posedge aclk);
		while (k < 4 && q.size() < 40) begin
			pat_valid <= 1'b1;
			pat_data  <= w;
			@(posedge aclk);
			if (pat_ready) begin
				q.push_back(w);
				w = 16'($urandom);
			end else
				k++;
		end
		pat_valid <= 1'b0;
		// Earlier triggers left a reload pending, so the first word lands at once
		rchk(IDX_ND_LO_ALT, {4'hf, q[0][3:0]});
		foreach (q[i]) begin
			trig(0);
			`CHK("stream", q[i][3:0], pad[3:0])
		end
		// FIFO now empty: the last word stays as next data
		e = q[q.size()-1][3:0];
		trig(0);
		`CHK("stream", e, pad[3:0])
		$display("test stream done");
		results();
	end
endmodule
